/* File: pkg/sideband_defines.svh */
// Purpose: shared constants of the sideband and power link
// Assumes: ref_clk at 10 MHz
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef SIDEBAND_DEFINES_SVH
`define SIDEBAND_DEFINES_SVH

`define REF_CLK_HZ          10000000
// power-ok and reset-release spacing, least time, rounded up
`define SEQ_DELAY_MS        1
`define SEQ_DELAY_CYCLES    ((`SEQ_DELAY_MS * `REF_CLK_HZ + 999) / 1000)
// regulator settling before power good is driven high
`define VR_SETTLE_US        50
`define VR_SETTLE_CYCLES    ((`VR_SETTLE_US * `REF_CLK_HZ + 999999) / 1000000)
// length of the soft-init pulse
`define INIT_PULSE_CYCLES   16
`define INIT_W              5
// half period of the sensor serial clock
`define SCL_HALF_CYCLES     5
`define HALF_W              4
// serial address of the thermal sensor, value is arbitrary
`define SENSOR_ADDR         7'h4c
// address bit forced low while the wrap mask is asserted
`define ADDR20_MASK         32'h0010_0000
`define TIMER_W             16
`define FRAME_BITS          18
`define FRAME_W             5

`endif

/* File: pkg/sideband_pkg.sv */
// Purpose: types of the sideband and power link
// Assumes: nothing
// Notes: state types have no fixed codes
package sideband_pkg;
	typedef logic [7:0]  temp_t;
	typedef logic [31:0] address_t;
	typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_SEND, SL_SEND_ACK} slave_state_t;
	typedef enum logic [2:0] {MS_IDLE, MS_START, MS_LOW, MS_HIGH, MS_STOP_LOW, MS_STOP_HIGH}
		master_state_t;
endpackage : sideband_pkg

/* File: pkg/sideband_if.sv */
// Purpose: wires between the processor module and the bridge
// Assumes: open-drain lines have pull-ups, power good has a pull-down
// Notes: an enable high means the owner pulls the line to its active level
`timescale 1ns/1ns
`default_nettype none
interface sideband_if;
	// bridge drives
	logic ignore_numeric_error_oe;
	logic soft_init_oe;
	logic maskable_irq_oe;
	logic nmi_oe;
	logic addr_bit20_mask_oe;
	logic sys_mgmt_irq_oe;
	logic stop_clock_req_oe;
	logic suspend_status_n;
	logic regulator_enable;
	logic bridge_power_ok;
	logic pci_bus_reset_n;
	logic sensor_clock_oe;
	logic sensor_data_host_oe;
	// module drives
	logic numeric_error_oe;
	logic regulator_power_good_oe;
	logic thermal_alert_oe;
	logic sensor_data_dev_oe;
	// resolved levels
	logic numeric_error_n;
	logic ignore_numeric_error_n;
	logic soft_init_n;
	logic maskable_irq;
	logic nmi;
	logic addr_bit20_mask_n;
	logic sys_mgmt_irq_n;
	logic stop_clock_req_n;
	logic regulator_power_good;
	logic thermal_alert_n;
	logic sensor_serial_clock;
	logic sensor_serial_data;

	assign numeric_error_n        = ~numeric_error_oe;
	assign ignore_numeric_error_n = ~ignore_numeric_error_oe;
	assign soft_init_n            = ~soft_init_oe;
	// active-high lines fall back low when released
	assign maskable_irq           = maskable_irq_oe;
	assign nmi                    = nmi_oe;
	assign addr_bit20_mask_n      = ~addr_bit20_mask_oe;
	assign sys_mgmt_irq_n         = ~sys_mgmt_irq_oe;
	assign stop_clock_req_n       = ~stop_clock_req_oe;
	assign regulator_power_good   = regulator_power_good_oe;
	assign thermal_alert_n        = ~thermal_alert_oe;
	assign sensor_serial_clock    = ~sensor_clock_oe;
	assign sensor_serial_data     = ~(sensor_data_host_oe | sensor_data_dev_oe);

	modport module_end (
		output numeric_error_oe, regulator_power_good_oe, thermal_alert_oe, sensor_data_dev_oe,
		input  ignore_numeric_error_n, soft_init_n, maskable_irq, nmi, addr_bit20_mask_n,
		input  sys_mgmt_irq_n, stop_clock_req_n, suspend_status_n, regulator_enable,
		input  bridge_power_ok, pci_bus_reset_n, sensor_serial_clock, sensor_serial_data
	);
	modport bridge_end (
		output ignore_numeric_error_oe, soft_init_oe, maskable_irq_oe, nmi_oe,
		output addr_bit20_mask_oe, sys_mgmt_irq_oe, stop_clock_req_oe, suspend_status_n,
		output regulator_enable, bridge_power_ok, pci_bus_reset_n, sensor_clock_oe,
		output sensor_data_host_oe,
		input  numeric_error_n, regulator_power_good, thermal_alert_n, sensor_serial_clock,
		input  sensor_serial_data
	);
endinterface : sideband_if
`default_nettype wire

/* File: hdl/settle_timer.sv */
// Purpose: flags that an enable has stood for COUNT cycles
// Assumes: COUNT fits the timer width
// Notes: dropping run clears the count at once
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.svh"
module settle_timer #(
	parameter int unsigned COUNT = 1
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic run,
	output logic      done
);
	localparam logic [`TIMER_W-1:0] LIMIT = `TIMER_W'(COUNT - 1);
	logic [`TIMER_W-1:0] count;

	always_ff @(posedge ref_clk) begin
		if (reset || !run) begin
			count <= '0;
			done  <= 1'b0;
		end else if (count == LIMIT) begin
			done  <= 1'b1;
		end else begin
			count <= count + `TIMER_W'(1);
		end
	end
endmodule : settle_timer
`default_nettype wire

/* File: hdl/module_sideband_end.sv */
// Purpose: processor module end of the sideband and power link
// Assumes: link inputs synchronous to ref_clk
// Notes: only reads of the sensor address are acknowledged
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.svh"
module module_sideband_end (
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	sideband_if.module_end            sb,
	input  wire logic                 coproc_error,
	input  wire sideband_pkg::address_t core_address,
	input  wire sideband_pkg::temp_t  temperature,
	input  wire sideband_pkg::temp_t  alert_limit,
	output sideband_pkg::address_t    bus_address,
	output logic                      ignore_error_active,
	output logic                      core_reinit,
	output logic                      irq_request,
	output logic                      nmi_request,
	output logic                      smi_request,
	output logic                      clock_stopped,
	output logic                      host_clock_may_stop,
	output logic                      bridge_in_reset
);
	import sideband_pkg::*;

	logic         vr_stable;
	logic         init_prev_n;
	logic         scl_q;
	logic         sda_q;
	logic [3:0]   bit_cnt;
	temp_t        shift;
	slave_state_t slave_state;
	logic         bus_start;
	logic         bus_stop;
	logic         scl_rise;
	logic         scl_fall;

	settle_timer #(.COUNT(`VR_SETTLE_CYCLES)) u_vr_timer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.run     (sb.regulator_enable),
		.done    (vr_stable)
	);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sb.numeric_error_oe        <= 1'b0;
			sb.regulator_power_good_oe <= 1'b0;
			sb.thermal_alert_oe        <= 1'b0;
		end else begin
			// [R1] [R19] error pulls low
			sb.numeric_error_oe        <= coproc_error;
			// [R13] high once stable
			sb.regulator_power_good_oe <= vr_stable & sb.regulator_enable;
			// [R17] [R19] alert pulls low
			sb.thermal_alert_oe        <= (temperature >= alert_limit);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bus_address <= '0;
		end else if (!sb.addr_bit20_mask_n) begin
			// [R6] wrap at 1 Mbyte
			bus_address <= core_address & ~`ADDR20_MASK;
		end else begin
			bus_address <= core_address;
		end
	end

	// [R9] [R10] stop state follows request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clock_stopped <= 1'b0;
		end else begin
			clock_stopped <= !sb.stop_clock_req_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			init_prev_n         <= 1'b1;
			core_reinit         <= 1'b0;
			ignore_error_active <= 1'b0;
			irq_request         <= 1'b0;
			nmi_request         <= 1'b0;
			smi_request         <= 1'b0;
			host_clock_may_stop <= 1'b0;
			bridge_in_reset     <= 1'b1;
		end else begin
			init_prev_n         <= sb.soft_init_n;
			core_reinit         <= init_prev_n & !sb.soft_init_n;
			ignore_error_active <= !sb.ignore_numeric_error_n;
			irq_request         <= sb.maskable_irq;
			nmi_request         <= sb.nmi;
			smi_request         <= !sb.sys_mgmt_irq_n;
			host_clock_may_stop <= !sb.suspend_status_n;
			bridge_in_reset     <= !sb.pci_bus_reset_n | !sb.bridge_power_ok;
		end
	end

	assign bus_start = sb.sensor_serial_clock & scl_q & sda_q & !sb.sensor_serial_data;
	assign bus_stop  = sb.sensor_serial_clock & scl_q & !sda_q & sb.sensor_serial_data;
	assign scl_rise  = sb.sensor_serial_clock & !scl_q;
	assign scl_fall  = !sb.sensor_serial_clock & scl_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= sb.sensor_serial_clock;
			sda_q <= sb.sensor_serial_data;
		end
	end

	// [R16] sensor serial target
	always_ff @(posedge ref_clk) begin
		if (reset || bus_stop) begin
			slave_state           <= SL_IDLE;
			sb.sensor_data_dev_oe <= 1'b0;
			bit_cnt               <= '0;
			shift                 <= '0;
		end else if (bus_start) begin
			slave_state           <= SL_ADDR;
			sb.sensor_data_dev_oe <= 1'b0;
			bit_cnt               <= '0;
		end else begin
			case (slave_state)
				SL_ADDR: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], sb.sensor_serial_data};
						bit_cnt <= bit_cnt + 4'd1;
					end else if (scl_fall && bit_cnt == 4'd8) begin
						// [R16] other addresses stay silent
						if (shift == {`SENSOR_ADDR, 1'b1}) begin
							sb.sensor_data_dev_oe <= 1'b1;
							slave_state           <= SL_ADDR_ACK;
						end else begin
							slave_state <= SL_IDLE;
						end
					end
				end
				SL_ADDR_ACK: begin
					if (scl_fall) begin
						sb.sensor_data_dev_oe <= !temperature[7];
						shift                 <= {temperature[6:0], 1'b0};
						bit_cnt               <= 4'd1;
						slave_state           <= SL_SEND;
					end
				end
				SL_SEND: begin
					if (scl_fall) begin
						if (bit_cnt == 4'd8) begin
							sb.sensor_data_dev_oe <= 1'b0;
							slave_state           <= SL_SEND_ACK;
						end else begin
							sb.sensor_data_dev_oe <= !shift[7];
							shift                 <= {shift[6:0], 1'b0};
							bit_cnt               <= bit_cnt + 4'd1;
						end
					end
				end
				SL_SEND_ACK: begin
					if (scl_rise) begin
						slave_state <= sb.sensor_serial_data ? SL_IDLE : SL_ADDR_ACK;
					end
				end
				default: begin
					sb.sensor_data_dev_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule : module_sideband_end
`default_nettype wire

/* File: hdl/bridge_sideband_end.sv */
// Purpose: bridge end of the processor module sideband and power link
// Assumes: single ref_clk domain, synchronous active-high reset
// Notes: pending requests hold until serviced, a new event beats a service
// Behaviour
// [R1] module pulls numeric error low on fault
// [R2] bridge drives ignore-error line open-drain
// [R3] bridge asserts soft init, module reinitialises
// [R4] interrupt request held until serviced
// [R5] nmi from system error or io check
// [R6] mask input forces address bit 20 low
// [R7] bridge raises management interrupt on events
// [R8] bridge drives stop-clock request on events
// [R9] module stops when stop request sampled
// [R10] module leaves stop only on deassertion
// [R11] suspend status asserted in every suspend
// [R12] regulator enable follows suspend-b control
// [R13] power good high only when regulator stable
// [R14] system power good combines regulator power good
// [R15] power ok 1 ms after rail, before reset
// [R16] sensor on serial bus, other addresses silent
// [R17] thermal alert on open-drain low line
// [R18] bus reset released only after power ok
// [R19] open-drain lines released when not asserted
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.svh"
module bridge_sideband_end #(
	parameter int unsigned POWER_OK_DELAY      = `SEQ_DELAY_CYCLES,
	parameter int unsigned RESET_RELEASE_DELAY = `SEQ_DELAY_CYCLES
) (
	input  wire logic          ref_clk,
	input  wire logic          reset,
	sideband_if.bridge_end     sb,
	input  wire logic          ignore_error_req,
	input  wire logic          init_req,
	input  wire logic          irq_raise,
	input  wire logic          irq_service,
	input  wire logic          serr_n,
	input  wire logic          io_check_n,
	input  wire logic          nmi_on_serr,
	input  wire logic          nmi_on_io_check_n,
	input  wire logic          nmi_service,
	input  wire logic          smi_event,
	input  wire logic          smi_service,
	input  wire logic          stop_clock_event,
	input  wire logic          stop_clock_release,
	input  wire logic          a20_mask_req,
	input  wire logic          suspend_active,
	input  wire logic          suspend_b_ctrl_n,
	input  wire logic          rail_3v3_stable,
	input  wire logic          board_power_ok,
	input  wire logic          sensor_read_start,
	output logic               fpu_error,
	output logic               thermal_alert,
	output logic               system_power_good,
	output logic               sequence_done,
	output sideband_pkg::temp_t sensor_data,
	output logic               sensor_done,
	output logic               sensor_nak,
	output logic               sensor_busy
);
	import sideband_pkg::*;

	localparam logic [`INIT_W-1:0]  INIT_LOAD = `INIT_W'(`INIT_PULSE_CYCLES);
	localparam logic [`HALF_W-1:0]  HALF_LAST = `HALF_W'(`SCL_HALF_CYCLES - 1);
	localparam logic [`FRAME_W-1:0] LAST_BIT  = `FRAME_W'(`FRAME_BITS - 1);

	logic                   power_ok_timer_done;
	logic                   release_timer_done;
	logic                   nmi_cause;
	logic [`INIT_W-1:0]     init_count;
	master_state_t          master_state;
	logic [`HALF_W-1:0]     half_cnt;
	logic                   tick;
	logic [`FRAME_W-1:0]    frame_idx;
	logic [`FRAME_BITS-1:0] tx_bits;
	logic [`FRAME_BITS-1:0] rx_bits;

	settle_timer #(.COUNT(POWER_OK_DELAY)) u_power_ok_timer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.run     (rail_3v3_stable),
		.done    (power_ok_timer_done)
	);

	settle_timer #(.COUNT(RESET_RELEASE_DELAY)) u_release_timer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.run     (sb.bridge_power_ok),
		.done    (release_timer_done)
	);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sb.bridge_power_ok <= 1'b0;
			sb.pci_bus_reset_n <= 1'b0;
			sequence_done      <= 1'b0;
		end else begin
			// [R15] power ok after rail delay
			sb.bridge_power_ok <= power_ok_timer_done & rail_3v3_stable;
			// [R18] [R15] release after power ok
			sb.pci_bus_reset_n <= release_timer_done & sb.bridge_power_ok;
			sequence_done      <= sb.pci_bus_reset_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sb.suspend_status_n <= 1'b1;
			sb.regulator_enable <= 1'b0;
			system_power_good   <= 1'b0;
		end else begin
			// [R11] suspend status
			sb.suspend_status_n <= !suspend_active;
			// [R12] enable from suspend-b
			sb.regulator_enable <= suspend_b_ctrl_n;
			// [R14] combined power good
			system_power_good   <= sb.regulator_power_good & board_power_ok;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fpu_error     <= 1'b0;
			thermal_alert <= 1'b0;
		end else begin
			fpu_error     <= !sb.numeric_error_n;
			thermal_alert <= !sb.thermal_alert_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sb.ignore_numeric_error_oe <= 1'b0;
			sb.addr_bit20_mask_oe      <= 1'b0;
		end else begin
			// [R2] [R19] ignore-error drive
			sb.ignore_numeric_error_oe <= ignore_error_req;
			sb.addr_bit20_mask_oe      <= a20_mask_req;
		end
	end

	// [R3] soft init pulse
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			init_count      <= '0;
			sb.soft_init_oe <= 1'b0;
		end else begin
			if (init_req) begin
				init_count <= INIT_LOAD;
			end else if (init_count != '0) begin
				init_count <= init_count - `INIT_W'(1);
			end
			sb.soft_init_oe <= init_req | (init_count > `INIT_W'(1));
		end
	end

	assign nmi_cause = (nmi_on_serr & !serr_n) | (nmi_on_io_check_n & !io_check_n);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sb.maskable_irq_oe   <= 1'b0;
			sb.nmi_oe            <= 1'b0;
			sb.sys_mgmt_irq_oe   <= 1'b0;
			sb.stop_clock_req_oe <= 1'b0;
		end else begin
			// [R4] hold until serviced
			sb.maskable_irq_oe   <= irq_raise | (sb.maskable_irq_oe & !irq_service);
			// [R5] selected error sources
			sb.nmi_oe            <= nmi_cause | (sb.nmi_oe & !nmi_service);
			// [R7] [R19] management interrupt
			sb.sys_mgmt_irq_oe   <= smi_event | (sb.sys_mgmt_irq_oe & !smi_service);
			// [R8] [R19] stop-clock request
			sb.stop_clock_req_oe <= stop_clock_event | (sb.stop_clock_req_oe & !stop_clock_release);
		end
	end

	// serial clock half-period tick, held at zero while idle
	assign tick = (half_cnt == HALF_LAST);

	always_ff @(posedge ref_clk) begin
		if (reset || master_state == MS_IDLE || tick) begin
			half_cnt <= '0;
		end else begin
			half_cnt <= half_cnt + `HALF_W'(1);
		end
	end

	// [R16] sensor read: address, ack, data byte, nak
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			master_state           <= MS_IDLE;
			sb.sensor_clock_oe     <= 1'b0;
			sb.sensor_data_host_oe <= 1'b0;
			frame_idx              <= '0;
			tx_bits                <= '0;
			rx_bits                <= '0;
			sensor_data            <= '0;
			sensor_done            <= 1'b0;
			sensor_nak             <= 1'b0;
			sensor_busy            <= 1'b0;
		end else begin
			sensor_done <= 1'b0;
			case (master_state)
				MS_IDLE: begin
					if (sensor_read_start) begin
						sb.sensor_data_host_oe <= 1'b1;
						tx_bits                <= {`SENSOR_ADDR, 1'b1, 10'h3ff};
						sensor_busy            <= 1'b1;
						master_state           <= MS_START;
					end
				end
				MS_START: begin
					if (tick) begin
						sb.sensor_clock_oe     <= 1'b1;
						sb.sensor_data_host_oe <= !tx_bits[`FRAME_BITS-1];
						frame_idx              <= '0;
						master_state           <= MS_LOW;
					end
				end
				MS_LOW: begin
					if (tick) begin
						sb.sensor_clock_oe <= 1'b0;
						master_state       <= MS_HIGH;
					end
				end
				MS_HIGH: begin
					if (tick) begin
						rx_bits            <= {rx_bits[`FRAME_BITS-2:0], sb.sensor_serial_data};
						sb.sensor_clock_oe <= 1'b1;
						if (frame_idx == LAST_BIT) begin
							sb.sensor_data_host_oe <= 1'b1;
							master_state           <= MS_STOP_LOW;
						end else begin
							sb.sensor_data_host_oe <= !tx_bits[`FRAME_BITS-2];
							tx_bits                <= {tx_bits[`FRAME_BITS-2:0], 1'b1};
							frame_idx              <= frame_idx + `FRAME_W'(1);
							master_state           <= MS_LOW;
						end
					end
				end
				MS_STOP_LOW: begin
					if (tick) begin
						sb.sensor_clock_oe <= 1'b0;
						master_state       <= MS_STOP_HIGH;
					end
				end
				MS_STOP_HIGH: begin
					if (tick) begin
						sb.sensor_data_host_oe <= 1'b0;
						sensor_data            <= rx_bits[8:1];
						sensor_nak             <= rx_bits[9];
						sensor_done            <= 1'b1;
						sensor_busy            <= 1'b0;
						master_state           <= MS_IDLE;
					end
				end
				default: begin
					master_state <= MS_IDLE;
				end
			endcase
		end
	end
endmodule : bridge_sideband_end
`default_nettype wire

/* File: verif/sideband_monitor.sv */
// Purpose: wire-level checks between the two link ends
// Assumes: one clock, reset synchronous and active high
// Notes: sees interface signals only
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.svh"
module sideband_monitor #(
	parameter int unsigned RESET_RELEASE_DELAY = 20
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic soft_init_oe,
	input wire logic maskable_irq_oe,
	input wire logic sys_mgmt_irq_oe,
	input wire logic stop_clock_req_oe,
	input wire logic bridge_power_ok,
	input wire logic pci_bus_reset_n,
	input wire logic regulator_enable,
	input wire logic regulator_power_good_oe,
	input wire logic sensor_data_dev_oe,
	input wire logic sensor_serial_clock
);
	logic [15:0] ok_cnt;
	logic [15:0] en_cnt;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// cycles that power ok and regulator enable have stood, saturating
	always_ff @(posedge ref_clk) begin
		ok_cnt <= (reset || !bridge_power_ok) ? 16'h0 : ok_cnt + 16'(ok_cnt != 16'hffff);
	end
	always_ff @(posedge ref_clk) begin
		en_cnt <= (reset || !regulator_enable) ? 16'h0 : en_cnt + 16'(en_cnt != 16'hffff);
	end

	a_release_after_reset: assert property ($fell(reset) |->
		!(soft_init_oe | maskable_irq_oe | sys_mgmt_irq_oe | stop_clock_req_oe))
		else $error("link line driven after reset");
	a_reset_needs_ok: assert property (!bridge_power_ok |=> !pci_bus_reset_n)
		else $error("bus reset released without power ok");
	a_reset_release_gap: assert property ($rose(pci_bus_reset_n) |->
		ok_cnt >= 16'(RESET_RELEASE_DELAY))
		else $error("bus reset released too soon after power ok");
	a_power_good_drop: assert property (!regulator_enable |=> !regulator_power_good_oe)
		else $error("power good kept without regulator enable");
	a_power_good_settle: assert property ($rose(regulator_power_good_oe) |->
		en_cnt >= 16'(`VR_SETTLE_CYCLES))
		else $error("power good before regulator settled");
	a_init_pulse_len: assert property ($rose(soft_init_oe) |-> ##15 soft_init_oe)
		else $error("soft init pulse too short");
	a_sda_stable_high: assert property ($changed(sensor_data_dev_oe) |-> !sensor_serial_clock)
		else $error("sensor data changed while clock high");
	a_scl_low_phase: assert property ($fell(sensor_serial_clock) |->
		(!sensor_serial_clock)[*5] ##1 sensor_serial_clock)
		else $error("serial clock low phase wrong");
endmodule : sideband_monitor
`default_nettype wire

/* File: verif/tb_cpu_sideband_power_control.sv */
// Purpose: both link ends joined, driven from their user sides
// Assumes: sequencing delays shortened to 20 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_sideband_power_control;
	import sideband_pkg::*;
	localparam int unsigned SEQ = 20;
	logic     ref_clk, reset, coproc_error, ignore_error_req, init_req, nmi_service, serr_n;
	logic     io_check_n, nmi_on_serr, nmi_on_io_check_n, a20_mask_req, suspend_active;
	logic     suspend_b_ctrl_n, rail_3v3_stable, board_power_ok, sensor_read_start;
	logic     ignore_error_active, core_reinit, irq_request, nmi_request, smi_request;
	logic     clock_stopped, host_clock_may_stop, bridge_in_reset, fpu_error, thermal_alert;
	logic     system_power_good, sequence_done, sensor_done, sensor_nak, sensor_busy;
	logic [2:0] ev, sv, req;
	address_t core_address, bus_address;
	temp_t    temperature, alert_limit, sensor_data;
	int       fails, n_checks;

	sideband_if sb();
	assign req = {clock_stopped, smi_request, irq_request};

	module_sideband_end u_module_sideband_end (.ref_clk, .reset, .sb(sb), .coproc_error,
		.core_address, .temperature, .alert_limit, .bus_address, .ignore_error_active,
		.core_reinit, .irq_request, .nmi_request, .smi_request, .clock_stopped,
		.host_clock_may_stop, .bridge_in_reset);
	bridge_sideband_end #(.POWER_OK_DELAY(SEQ), .RESET_RELEASE_DELAY(SEQ)) u_bridge_sideband_end (
		.ref_clk, .reset, .sb(sb), .ignore_error_req, .init_req, .irq_raise(ev[0]),
		.irq_service(sv[0]), .serr_n, .io_check_n, .nmi_on_serr, .nmi_on_io_check_n, .nmi_service,
		.smi_event(ev[1]), .smi_service(sv[1]), .stop_clock_event(ev[2]),
		.stop_clock_release(sv[2]), .a20_mask_req, .suspend_active, .suspend_b_ctrl_n,
		.rail_3v3_stable, .board_power_ok, .sensor_read_start, .fpu_error, .thermal_alert,
		.system_power_good, .sequence_done, .sensor_data, .sensor_done, .sensor_nak, .sensor_busy);
	sideband_monitor #(.RESET_RELEASE_DELAY(SEQ)) u_sideband_monitor (.ref_clk, .reset,
		.soft_init_oe(sb.soft_init_oe), .maskable_irq_oe(sb.maskable_irq_oe),
		.sys_mgmt_irq_oe(sb.sys_mgmt_irq_oe), .stop_clock_req_oe(sb.stop_clock_req_oe),
		.bridge_power_ok(sb.bridge_power_ok), .pci_bus_reset_n(sb.pci_bus_reset_n),
		.regulator_enable(sb.regulator_enable),
		.regulator_power_good_oe(sb.regulator_power_good_oe),
		.sensor_data_dev_oe(sb.sensor_data_dev_oe), .sensor_serial_clock(sb.sensor_serial_clock));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic final_report();
		if (fails == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic wait_for(input string what, ref logic sig, input int lim, output int t);
		t = 0;
		while (sig !== 1'b1) begin
			cyc(1);
			t++;
			if (t > lim) begin
				fails++;
				$display("unexpected %s: expected 1, seen timeout", what);
				final_report();
			end
		end
	endtask : wait_for

	task automatic t_power();
		int t0;
		int t1;
		chk("early reset", bridge_in_reset, 1);
		wait_for("sequence", sequence_done, 200, t0);
		chk("sequence time", t0 >= 2 * SEQ && t0 <= 2 * SEQ + 6, 1);
		chk("bus reset", {sb.pci_bus_reset_n, bridge_in_reset}, 2'b10);
		wait_for("power good", system_power_good, 800, t1);
		chk("settle time", t0 + t1 >= 500, 1);
		board_power_ok = 1'b0;
		cyc(3);
		chk("system good", system_power_good, 0);
		board_power_ok = 1'b1;
		suspend_b_ctrl_n = 1'b0;
		cyc(4);
		chk("regulator off", {sb.regulator_enable, sb.regulator_power_good}, 2'b00);
	endtask : t_power

	task automatic t_sticky();
		for (int k = 0; k < 3; k++) begin
			ev[k] = 1'b1;
			cyc(1);
			ev[k] = 1'b0;
			cyc(3);
			chk("request set", req[k], 1);
			ev[k] = 1'b1;
			sv[k] = 1'b1;
			cyc(1);
			ev[k] = 1'b0;
			sv[k] = 1'b0;
			cyc(3);
			chk("request kept", req[k], 1);
			sv[k] = 1'b1;
			cyc(1);
			sv[k] = 1'b0;
			cyc(3);
			chk("request cleared", req[k], 0);
		end
		chk("lines idle", {sb.sys_mgmt_irq_n, sb.stop_clock_req_n, sb.maskable_irq}, 3'b110);
	endtask : t_sticky

	task automatic t_nmi();
		serr_n = 1'b0;
		cyc(3);
		chk("nmi masked", nmi_request, 0);
		nmi_on_serr = 1'b1;
		cyc(3);
		chk("nmi system error", nmi_request, 1);
		serr_n = 1'b1;
		nmi_on_io_check_n = 1'b1;
		io_check_n = 1'b0;
		nmi_service = 1'b1;
		cyc(3);
		chk("nmi io check", nmi_request, 1);
		io_check_n = 1'b1;
		cyc(3);
		chk("nmi cleared", {nmi_request, sb.nmi}, 2'b00);
		nmi_service = 1'b0;
	endtask : t_nmi

	task automatic t_levels();
		coproc_error = 1'b1;
		ignore_error_req = 1'b1;
		suspend_active = 1'b1;
		a20_mask_req = 1'b1;
		temperature = 8'h5a;
		alert_limit = 8'h5a;
		cyc(4);
		chk("fault", {sb.numeric_error_n, fpu_error}, 2'b01);
		chk("ignore error", ignore_error_active, 1);
		chk("suspend", host_clock_may_stop, 1);
		chk("wrapped address", bus_address, 32'h0002_3456);
		chk("alert", {sb.thermal_alert_n, thermal_alert}, 2'b01);
		{coproc_error, ignore_error_req, suspend_active, a20_mask_req} = 4'h0;
		alert_limit = 8'h5b;
		cyc(4);
		chk("levels clear", {fpu_error, ignore_error_active, host_clock_may_stop}, 0);
		chk("full address", bus_address, 32'h0012_3456);
		chk("alert clear", {sb.thermal_alert_n, thermal_alert}, 2'b10);
	endtask : t_levels

	task automatic t_init();
		init_req = 1'b1;
		cyc(1);
		init_req = 1'b0;
		cyc(1);
		chk("init line", {sb.soft_init_n, core_reinit}, 2'b01);
		cyc(1);
		chk("reinit pulse", core_reinit, 0);
		cyc(13);
		chk("init held", sb.soft_init_n, 0);
		cyc(1);
		chk("init released", sb.soft_init_n, 1);
	endtask : t_init

	task automatic t_sensor();
		int t;
		temperature = 8'hc3;
		sensor_read_start = 1'b1;
		cyc(1);
		sensor_read_start = 1'b0;
		cyc(20);
		chk("sensor busy", sensor_busy, 1);
		sensor_read_start = 1'b1;
		cyc(1);
		sensor_read_start = 1'b0;
		wait_for("sensor done", sensor_done, 400, t);
		chk("sensor reply", {sensor_nak, sensor_data}, 9'h0c3);
		cyc(250);
		chk("idle", {sensor_busy, sb.sensor_serial_clock, sb.sensor_serial_data}, 3'b011);
	endtask : t_sensor

	initial begin
		reset = 1'b1;
		{coproc_error, ignore_error_req, init_req, nmi_service, nmi_on_serr} = 5'h0;
		{nmi_on_io_check_n, a20_mask_req, suspend_active, sensor_read_start} = 4'h0;
		{serr_n, io_check_n, suspend_b_ctrl_n, rail_3v3_stable, board_power_ok} = 5'h1f;
		ev = 3'h0;
		sv = 3'h0;
		core_address = 32'h0012_3456;
		temperature = 8'h00;
		alert_limit = 8'hff;
		fails = 0;
		n_checks = 0;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		cyc(2);
		t_power();
		t_sticky();
		t_nmi();
		t_levels();
		t_init();
		t_sensor();
		rail_3v3_stable = 1'b0;
		cyc(3);
		chk("rail drop", {sb.pci_bus_reset_n, bridge_in_reset}, 2'b01);
		final_report();
	end
endmodule : tb_cpu_sideband_power_control
`default_nettype wire
